// *** design/llrc_top.v ***
// Implementation choice: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "llrc_regs.vh"

module llrc_top (
	input wire aclk,
	input wire aresetn,
	input wire [11:0] s_axi_awaddr,
	input wire [2:0] s_axi_awprot,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [11:0] s_axi_araddr,
	input wire [2:0] s_axi_arprot,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	output wire core_run,
	output wire core_rate_valid,
	output wire [9:0] core_rate_khz,
	output wire slow_ratio_valid,
	output wire [3:0] slow_div,
	output wire sleep_en,
	output wire [4:0] sleep_addr,
	output wire sleep_cfg_valid,
	output wire pair_a_sinc_third,
	output wire pair_a_rate_valid,
	output wire [9:0] pair_a_sample_rate,
	output wire pair_b_sinc_third,
	output wire pair_b_rate_valid,
	output wire [9:0] pair_b_sample_rate
);
	// Shadow copies hold what software wrote; active copies feed the core
	reg [7:0] core_sh_q;
	reg [7:0] sleep_sh_q;
	reg [7:0] adc_a_sh_q;
	reg [7:0] adc_b_sh_q;
	reg [7:0] core_act_q;
	reg [7:0] sleep_act_q;
	reg [7:0] adc_a_act_q;
	reg [7:0] adc_b_act_q;
	reg [7:0] run_q;

	reg aw_have_q;
	reg [9:0] aw_idx_q;
	reg w_have_q;
	reg [7:0] w_byte_q;
	reg w_lane_q;

	wire pending;
	wire match_a;
	wire match_b;
	wire do_write;
	wire [9:0] ar_idx;
	reg [31:0] rd_d;
	reg rd_ok_d;

	function is_mapped;
		input [9:0] idx;
		begin
			is_mapped = (idx == `LLRC_IDX_CORE) || (idx == `LLRC_IDX_SLEEP) ||
				(idx == `LLRC_IDX_ADC_A) || (idx == `LLRC_IDX_ADC_B) ||
				(idx == `LLRC_IDX_RUN) || (idx == `LLRC_IDX_STAT);
		end
	endfunction

	// Register index from a byte address; low two bits ignored
	function [9:0] word_idx;
		input [11:0] addr;
		begin
			word_idx = addr[11:2];
		end
	endfunction

	assign core_run = run_q[`LLRC_RUN_BIT];

	// Write address and data are taken in either order, one write at a time
	assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
	assign s_axi_wready = !w_have_q && !s_axi_bvalid;
	assign do_write = aw_have_q && w_have_q && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;
	assign ar_idx = word_idx(s_axi_araddr);

	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_q <= 1'b0;
			aw_idx_q <= 10'h000;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_have_q <= 1'b1;
			aw_idx_q <= word_idx(s_axi_awaddr);
		end else if (do_write) begin
			aw_have_q <= 1'b0;
		end
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			w_have_q <= 1'b0;
			w_byte_q <= 8'h00;
			w_lane_q <= 1'b0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_have_q <= 1'b1;
			w_byte_q <= s_axi_wdata[7:0];
			w_lane_q <= s_axi_wstrb[0];
		end else if (do_write) begin
			w_have_q <= 1'b0;
		end
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `LLRC_RESP_OKAY;
		end else if (do_write) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= is_mapped(aw_idx_q) ? `LLRC_RESP_OKAY : `LLRC_RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Shadow writes with byte lane 0 strobed are taken even while running; the core only sees them when stopped
	always @(posedge aclk) begin
		if (!aresetn) begin
			core_sh_q <= `LLRC_RST_CORE;
			sleep_sh_q <= `LLRC_RST_SLEEP;
			adc_a_sh_q <= `LLRC_RST_ADC;
			adc_b_sh_q <= `LLRC_RST_ADC;
			run_q <= `LLRC_RST_RUN;
		end else if (do_write && w_lane_q) begin
			case (aw_idx_q)
				`LLRC_IDX_CORE: begin
					core_sh_q <= w_byte_q & `LLRC_MASK_CORE;
				end
				`LLRC_IDX_SLEEP: begin
					sleep_sh_q <= w_byte_q & `LLRC_MASK_SLEEP;
				end
				`LLRC_IDX_ADC_A: begin
					adc_a_sh_q <= w_byte_q & `LLRC_MASK_ADC;
				end
				`LLRC_IDX_ADC_B: begin
					adc_b_sh_q <= w_byte_q & `LLRC_MASK_ADC;
				end
				`LLRC_IDX_RUN: begin
					run_q <= w_byte_q & `LLRC_MASK_RUN;
				end
				default: begin
				end
			endcase
		end
	end

	// Frozen while running, so a careless write cannot glitch the core
	always @(posedge aclk) begin
		if (!aresetn) begin
			core_act_q <= `LLRC_RST_CORE;
			sleep_act_q <= `LLRC_RST_SLEEP;
			adc_a_act_q <= `LLRC_RST_ADC;
			adc_b_act_q <= `LLRC_RST_ADC;
		end else if (!core_run) begin
			core_act_q <= core_sh_q;
			sleep_act_q <= sleep_sh_q;
			adc_a_act_q <= adc_a_sh_q;
			adc_b_act_q <= adc_b_sh_q;
		end
	end

	assign pending = (core_sh_q != core_act_q) || (sleep_sh_q != sleep_act_q) ||
		(adc_a_sh_q != adc_a_act_q) || (adc_b_sh_q != adc_b_act_q);

	llrc_core_dec u_core_dec (
		.aclk(aclk),
		.aresetn(aresetn),
		.core_reg(core_act_q),
		.sleep_reg(sleep_act_q),
		.core_rate_valid(core_rate_valid),
		.core_rate_khz(core_rate_khz),
		.slow_ratio_valid(slow_ratio_valid),
		.slow_div(slow_div),
		.sleep_en(sleep_en),
		.sleep_addr(sleep_addr),
		.sleep_cfg_valid(sleep_cfg_valid)
	);

	llrc_adc_dec u_adc_a_dec (
		.aclk(aclk),
		.aresetn(aresetn),
		.adc_reg(adc_a_act_q),
		.sinc_third(pair_a_sinc_third),
		.rate_valid(pair_a_rate_valid),
		.rate_khz(pair_a_sample_rate)
	);

	llrc_adc_dec u_adc_b_dec (
		.aclk(aclk),
		.aresetn(aresetn),
		.adc_reg(adc_b_act_q),
		.sinc_third(pair_b_sinc_third),
		.rate_valid(pair_b_rate_valid),
		.rate_khz(pair_b_sample_rate)
	);

	// Codes differ between fields, so compare frequencies, not codes
	assign match_a = core_rate_valid && pair_a_rate_valid &&
		(core_rate_khz == pair_a_sample_rate);
	assign match_b = core_rate_valid && pair_b_rate_valid &&
		(core_rate_khz == pair_b_sample_rate);

	always @* begin
		rd_d = 32'h00000000;
		rd_ok_d = 1'b1;
		case (ar_idx)
			`LLRC_IDX_CORE: begin
				rd_d = {24'h000000, core_sh_q};
			end
			`LLRC_IDX_SLEEP: begin
				rd_d = {24'h000000, sleep_sh_q};
			end
			`LLRC_IDX_ADC_A: begin
				rd_d = {24'h000000, adc_a_sh_q};
			end
			`LLRC_IDX_ADC_B: begin
				rd_d = {24'h000000, adc_b_sh_q};
			end
			`LLRC_IDX_RUN: begin
				rd_d = {24'h000000, run_q};
			end
			`LLRC_IDX_STAT: begin
				rd_d = {23'h000000, match_b, match_a, pair_b_rate_valid,
					pair_a_rate_valid, sleep_cfg_valid, slow_ratio_valid,
					core_rate_valid, pending, core_run};
			end
			default: begin
				rd_ok_d = 1'b0;
			end
		endcase
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `LLRC_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_d;
			s_axi_rresp <= rd_ok_d ? `LLRC_RESP_OKAY : `LLRC_RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// *** design/llrc_regs.vh ***
`ifndef LLRC_REGS_VH
`define LLRC_REGS_VH

// Register indices; byte address is four times the index
`define LLRC_IDX_CORE 10'h009
`define LLRC_IDX_SLEEP 10'h00a
`define LLRC_IDX_ADC_A 10'h01b
`define LLRC_IDX_ADC_B 10'h01c
`define LLRC_IDX_RUN 10'h020
`define LLRC_IDX_STAT 10'h021

// Implemented bits of each register, the rest read as zero
`define LLRC_MASK_CORE 8'h1e
`define LLRC_MASK_SLEEP 8'h1f
`define LLRC_MASK_ADC 8'h23
`define LLRC_MASK_RUN 8'h01

// Reset values: core at 96 kHz, ADC pairs at 96 kHz
`define LLRC_RST_CORE 8'h02
`define LLRC_RST_SLEEP 8'h00
`define LLRC_RST_ADC 8'h00
`define LLRC_RST_RUN 8'h00

// Field positions
`define LLRC_SLOW_HI 4
`define LLRC_SLOW_LO 3
`define LLRC_CFS_HI 2
`define LLRC_CFS_LO 1
`define LLRC_SLEEP_HI 4
`define LLRC_SLEEP_LO 0
`define LLRC_SINC_BIT 5
`define LLRC_AFS_HI 1
`define LLRC_AFS_LO 0
`define LLRC_RUN_BIT 0

// Rates in kHz and slow-rate divisors
`define LLRC_KHZ_NONE 10'h000
`define LLRC_KHZ_96 10'h060
`define LLRC_KHZ_192 10'h0c0
`define LLRC_KHZ_768 10'h300
`define LLRC_DIV_1 4'h1
`define LLRC_DIV_4 4'h4
`define LLRC_DIV_8 4'h8
`define LLRC_DIV_NONE 4'h0
`define LLRC_SLEEP_OFS 5'h02

// Bus answers
`define LLRC_RESP_OKAY 2'h0
`define LLRC_RESP_SLVERR 2'h2

`endif

// *** design/llrc_core_dec.v ***
`timescale 1ns/1ps
`default_nettype none
`include "llrc_regs.vh"

module llrc_core_dec (
	input wire aclk,
	input wire aresetn,
	input wire [7:0] core_reg,
	input wire [7:0] sleep_reg,
	output reg core_rate_valid,
	output reg [9:0] core_rate_khz,
	output reg slow_ratio_valid,
	output reg [3:0] slow_div,
	output reg sleep_en,
	output reg [4:0] sleep_addr,
	output reg sleep_cfg_valid
);
	wire [1:0] cfs = core_reg[`LLRC_CFS_HI:`LLRC_CFS_LO];
	wire [1:0] ratio = core_reg[`LLRC_SLOW_HI:`LLRC_SLOW_LO];
	wire [4:0] n = sleep_reg[`LLRC_SLEEP_HI:`LLRC_SLEEP_LO];

	always @(posedge aclk) begin
		if (!aresetn) begin
			core_rate_valid <= 1'b0;
			core_rate_khz <= `LLRC_KHZ_NONE;
			slow_ratio_valid <= 1'b0;
			slow_div <= `LLRC_DIV_NONE;
			sleep_en <= 1'b0;
			sleep_addr <= 5'h00;
			sleep_cfg_valid <= 1'b0;
		end else begin
			case (cfs)
				2'h1: core_rate_khz <= `LLRC_KHZ_96;
				2'h2: core_rate_khz <= `LLRC_KHZ_192;
				2'h3: core_rate_khz <= `LLRC_KHZ_768;
				default: core_rate_khz <= `LLRC_KHZ_NONE;
			endcase
			core_rate_valid <= (cfs != 2'h0);
			case (ratio)
				2'h0: slow_div <= `LLRC_DIV_1;
				2'h1: slow_div <= `LLRC_DIV_4;
				2'h2: slow_div <= `LLRC_DIV_8;
				default: slow_div <= `LLRC_DIV_NONE;
			endcase
			slow_ratio_valid <= (ratio != 2'h3);
			// Reserved count 1 neither sleeps nor reports valid
			sleep_en <= (n >= `LLRC_SLEEP_OFS);
			sleep_addr <= (n >= `LLRC_SLEEP_OFS) ? n - `LLRC_SLEEP_OFS : 5'h00;
			sleep_cfg_valid <= (n != 5'h01);
		end
	end
endmodule
`default_nettype wire

// *** design/llrc_adc_dec.v ***
`timescale 1ns/1ps
`default_nettype none
`include "llrc_regs.vh"

module llrc_adc_dec (
	input wire aclk,
	input wire aresetn,
	input wire [7:0] adc_reg,
	output reg sinc_third,
	output reg rate_valid,
	output reg [9:0] rate_khz
);
	wire [1:0] fs = adc_reg[`LLRC_AFS_HI:`LLRC_AFS_LO];

	always @(posedge aclk) begin
		if (!aresetn) begin
			sinc_third <= 1'b0;
			rate_valid <= 1'b0;
			rate_khz <= `LLRC_KHZ_NONE;
		end else begin
			sinc_third <= adc_reg[`LLRC_SINC_BIT];
			case (fs)
				2'h0: rate_khz <= `LLRC_KHZ_96;
				2'h1: rate_khz <= `LLRC_KHZ_192;
				2'h2: rate_khz <= `LLRC_KHZ_768;
				default: rate_khz <= `LLRC_KHZ_NONE;
			endcase
			rate_valid <= (fs != 2'h3);
		end
	end
endmodule
`default_nettype wire

// *** testbench/llrc_top_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
module llrc_chk (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic core_run,
	input wire logic core_rate_valid,
	input wire logic [9:0] core_rate_khz,
	input wire logic slow_ratio_valid,
	input wire logic [3:0] slow_div,
	input wire logic sleep_en,
	input wire logic [4:0] sleep_addr,
	input wire logic sleep_cfg_valid,
	input wire logic pair_a_rate_valid,
	input wire logic [9:0] pair_a_sample_rate
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
		&& $stable(s_axi_bresp)) else $error("write response dropped");
	rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
		else $error("read response dropped");
	core_rate_a: assert property (core_rate_valid ? core_rate_khz inside {10'h060, 10'h0c0,
		10'h300} : core_rate_khz == 10'h000) else $error("core rate decode");
	slow_div_a: assert property (slow_ratio_valid ? slow_div inside {4'h1, 4'h4, 4'h8}
		: slow_div == 4'h0) else $error("slow ratio decode");
	sleep_addr_a: assert property (sleep_en ? sleep_cfg_valid : sleep_addr == 5'h00)
		else $error("sleep decode");
	sleep_cfg_a: assert property (!sleep_cfg_valid |-> !sleep_en)
		else $error("reserved sleep count sleeps");
	pair_rate_a: assert property (pair_a_rate_valid ? pair_a_sample_rate inside {10'h060,
		10'h0c0, 10'h300} : pair_a_sample_rate == 10'h000) else $error("pair rate decode");
	// Two cycles of run needed: the load taken as run rises lands one edge later
	run_freeze_a: assert property (core_run && $past(core_run) && $past(core_run, 2)
		|-> $stable(core_rate_khz) && $stable(slow_div) && $stable(sleep_addr)
		&& $stable(pair_a_sample_rate)) else $error("settings changed while running");
	cover property (core_run && $past(core_run, 2));
	cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
	cover property (sleep_en && !slow_ratio_valid);
endmodule
bind llrc_top llrc_chk chk (.aclk(aclk), .aresetn(aresetn), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .core_run(core_run), .core_rate_valid(core_rate_valid),
	.core_rate_khz(core_rate_khz), .slow_ratio_valid(slow_ratio_valid), .slow_div(slow_div),
	.sleep_en(sleep_en), .sleep_addr(sleep_addr), .sleep_cfg_valid(sleep_cfg_valid),
	.pair_a_rate_valid(pair_a_rate_valid), .pair_a_sample_rate(pair_a_sample_rate));
`default_nettype wire

// *** testbench/llrc_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic aclk, aresetn, awv, wv, bready, arv, rready, awr, wr_r, arr, bv, rv;
	logic run, crv, srv, sen, scv, asn, arv2, bsn, brv2;
	logic [11:0] awa, ara;
	logic [31:0] wd, rdat;
	logic [1:0] br, rr;
	logic [9:0] ckhz, akhz, bkhz;
	logic [3:0] sdiv;
	logic [4:0] sadr;
	logic [10:0] kt [4] = '{11'h000, 11'h460, 11'h4c0, 11'h700};
	logic [10:0] at [4] = '{11'h460, 11'h4c0, 11'h700, 11'h000};
	logic [4:0] dt [4] = '{5'h11, 5'h14, 5'h18, 5'h00};
	int sl [6] = '{0, 1, 2, 3, 7, 31};
	int err_count = 0;
	int checks_done = 0;
	int cyc = 0;
	llrc_top uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awprot(3'h0),
		.s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
		.s_axi_wvalid(wv), .s_axi_wready(wr_r), .s_axi_bresp(br), .s_axi_bvalid(bv),
		.s_axi_bready(bready), .s_axi_araddr(ara), .s_axi_arprot(3'h0), .s_axi_arvalid(arv),
		.s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv),
		.s_axi_rready(rready), .core_run(run), .core_rate_valid(crv), .core_rate_khz(ckhz),
		.slow_ratio_valid(srv), .slow_div(sdiv), .sleep_en(sen), .sleep_addr(sadr),
		.sleep_cfg_valid(scv), .pair_a_sinc_third(asn), .pair_a_rate_valid(arv2),
		.pair_a_sample_rate(akhz), .pair_b_sinc_third(bsn), .pair_b_rate_valid(brv2),
		.pair_b_sample_rate(bkhz));
	initial begin
		aclk = 1'b0;
		forever #25 aclk = ~aclk;
	end
	task conclude;
		if (err_count == 0 && checks_done > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 5000) begin
			err_count++;
			conclude;
		end
	end
	task chk(input logic [31:0] g, input logic [31:0] e);
		checks_done++;
		if (g !== e) begin
			err_count++;
			$display("MISMATCH %0t got %h exp %h", $time, g, e);
		end
	endtask
	// Handshakes are judged at the falling edge, so readies never race the driving edge
	task wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] e);
		logic ta, tw;
		@(posedge aclk);
		awa <= a;
		wd <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		bready <= 1'b1;
		do begin
			@(negedge aclk);
			ta = awv && awr;
			tw = wv && wr_r;
			@(posedge aclk);
			if (ta) awv <= 1'b0;
			if (tw) wv <= 1'b0;
		end while (awv || wv);
		do @(negedge aclk); while (!bv);
		chk(br, e);
		@(posedge aclk);
		bready <= 1'b0;
	endtask
	task rc(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
		@(posedge aclk);
		ara <= a;
		arv <= 1'b1;
		rready <= 1'b1;
		do @(negedge aclk); while (!arr);
		@(posedge aclk);
		arv <= 1'b0;
		do @(negedge aclk); while (!rv);
		chk(rdat, e);
		chk(rr, er);
		@(posedge aclk);
		rready <= 1'b0;
	endtask
	task st;
		repeat (3) @(posedge aclk);
		@(negedge aclk);
	endtask
	task s_reset;
		rc(12'h024, 32'h2, 2'h0);
		rc(12'h06c, 32'h0, 2'h0);
		rc(12'h080, 32'h0, 2'h0);
		wr(12'h3fc, 32'h0, 2'h2);
		chk({run, crv, ckhz, srv, sdiv, scv, sen}, {2'h1, 10'h060, 1'b1, 4'h1, 2'h2});
		chk({arv2, akhz, brv2, bkhz}, {1'b1, 10'h060, 1'b1, 10'h060});
	endtask
	task s_core;
		for (int i = 0; i < 16; i++) begin
			wr(12'h024, 32'(i * 2), 2'h0);
			st;
			chk({crv, ckhz}, kt[i & 3]);
			chk({srv, sdiv}, dt[i >> 2]);
			rc(12'h024, 32'(i * 2), 2'h0);
		end
	endtask
	task s_sleep;
		for (int k = 0; k < 6; k++) begin
			wr(12'h028, 32'(sl[k]), 2'h0);
			st;
			chk({scv, sen, sadr}, {sl[k] != 1, sl[k] >= 2, 5'(sl[k] >= 2 ? sl[k] - 2 : 0)});
		end
	endtask
	task s_adc;
		logic [7:0] v8;
		// Upper bits are set too, so the readback also proves the field mask
		for (int p = 0; p < 2; p++) begin
			for (int v = 0; v < 8; v++) begin
				v8 = 8'hc0 | 8'((v & 4) << 3) | 8'(v & 3);
				wr(p ? 12'h070 : 12'h06c, 32'(v8), 2'h0);
				st;
				chk(p ? {bsn, brv2, bkhz} : {asn, arv2, akhz}, {v[2], at[v & 3]});
				rc(p ? 12'h070 : 12'h06c, 32'(v8 & 8'h23), 2'h0);
			end
		end
	endtask
	task s_run;
		wr(12'h024, 32'h4, 2'h0);
		wr(12'h028, 32'h0, 2'h0);
		wr(12'h06c, 32'h1, 2'h0);
		wr(12'h080, 32'h1, 2'h0);
		wr(12'h024, 32'he, 2'h0);
		wr(12'h028, 32'h7, 2'h0);
		wr(12'h06c, 32'h2, 2'h0);
		wr(12'h070, 32'h2, 2'h0);
		st;
		chk({run, ckhz, sdiv, sadr, akhz}, {1'b1, 10'h0c0, 4'h1, 5'h0, 10'h0c0});
		rc(12'h024, 32'he, 2'h0);
		// Pair B still holds the reserved rate from the sweep, so only pair A matches
		rc(12'h084, 32'h0bf, 2'h0);
		wr(12'h080, 32'h0, 2'h0);
		st;
		chk({run, ckhz, sdiv, sadr, akhz}, {1'b0, 10'h300, 4'h4, 5'h5, 10'h300});
		rc(12'h084, 32'h1fc, 2'h0);
	endtask
	initial begin
		aresetn = 1'b0;
		awv = 1'b0;
		wv = 1'b0;
		bready = 1'b0;
		arv = 1'b0;
		rready = 1'b0;
		awa = 12'h000;
		ara = 12'h000;
		wd = 32'h0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		s_reset;
		s_core;
		s_sleep;
		s_adc;
		s_run;
		conclude;
	end
endmodule
`default_nettype wire
